/* design/external_bus_pin_interface.sv */
`timescale 1ns/100ps
// Summary of operation
// - The read strobe goes active while an external read is on the bus so the part can drive data.
// - The low-byte store strobe goes active when a write carries data on the lower eight data lines.
// - The high-byte store strobe goes active when a write carries data on the upper eight data lines.
// - A slow part holding the wait input low stretches the strobe phase of the cycle for as long as it does.
// - A bus release request floats the data, address, strobe, direction, row strobe and select pins.
// - Once those pins float, the bus release grant goes active to tell the requester the bus is free.
// - The direction output is high in read and dummy cycles and low in write cycles.
// - Accesses to external DRAM drive the row address strobe.
// - Select line zero is low while the bus address lies in its programmed range, high otherwise.
// - With area zero set for DRAM, that pin carries column strobe zero for accesses inside area zero.
module external_bus_pin_interface (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Internal bus master
  input wire ext_bus_pkg::cpu_req_t cpu_req,
  output ext_bus_pkg::cpu_resp_t cpu_resp,
  // Address area setup
  input wire ext_bus_pkg::area_cfg_t area_cfg,
  // External pins
  input wire ext_bus_pkg::pins_in_t pins_in,
  output ext_bus_pkg::pins_out_t pins_out
);

  ext_bus_pkg::bus_state_t state_ff;
  ext_bus_pkg::bus_state_t nxt_state;
  ext_bus_pkg::cpu_req_t req_ff;
  ext_bus_pkg::cpu_req_t nxt_req;
  logic [ext_bus_pkg::AREA_N-1:0] hit_ff;
  logic [ext_bus_pkg::AREA_N-1:0] nxt_hit;
  logic [ext_bus_pkg::AREA_N-1:0] area_hit;
  ext_bus_pkg::cpu_resp_t resp_ff;
  ext_bus_pkg::cpu_resp_t nxt_resp;
  ext_bus_pkg::pins_out_t pins_ff;
  ext_bus_pkg::pins_out_t nxt_pins;
  logic dram_cyc;
  logic nxt_dram;

  // Range compare of the incoming address against each area
  genvar gi;
  generate
    for (gi = 0; gi < ext_bus_pkg::AREA_N; gi++) begin : g_area
      assign area_hit[gi] = ((cpu_req.addr & area_cfg.mask[gi]) ==
                             (area_cfg.base[gi] & area_cfg.mask[gi]));
    end
  endgenerate

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_hit = hit_ff;
    nxt_dram = dram_cyc;
    case (state_ff)
      ext_bus_pkg::ST_IDLE: begin
        if (!pins_in.bus_release_request_n) begin
          nxt_state = ext_bus_pkg::ST_FLOAT;
        end else if (cpu_req.valid) begin
          nxt_state = ext_bus_pkg::ST_ADDR;
          nxt_req = cpu_req;
          nxt_hit = area_hit;
          nxt_dram = area_cfg.area0_dram & area_hit[0];
        end
      end
      ext_bus_pkg::ST_ADDR: begin
        nxt_state = ext_bus_pkg::ST_STROBE;
      end
      ext_bus_pkg::ST_STROBE: begin
        if (pins_in.bus_wait_n) begin
          nxt_state = ext_bus_pkg::ST_END;
        end
      end
      ext_bus_pkg::ST_END: begin
        nxt_state = ext_bus_pkg::ST_IDLE;
        nxt_req.valid = 1'h0;
      end
      ext_bus_pkg::ST_FLOAT: begin
        nxt_state = ext_bus_pkg::ST_HOLD;
      end
      ext_bus_pkg::ST_HOLD: begin
        if (pins_in.bus_release_request_n) begin
          nxt_state = ext_bus_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = ext_bus_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ext_bus_pkg::ST_IDLE;
      req_ff <= '0;
      hit_ff <= '0;
      dram_cyc <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      hit_ff <= nxt_hit;
      dram_cyc <= nxt_dram;
    end
  end

  // Answer to the internal master
  always_comb begin
    nxt_resp.ack = 1'h0;
    nxt_resp.rdata = resp_ff.rdata;
    nxt_resp.released = (nxt_state == ext_bus_pkg::ST_HOLD);
    if (state_ff == ext_bus_pkg::ST_STROBE && pins_in.bus_wait_n) begin
      nxt_resp.ack = 1'h1;
      if (!req_ff.write) begin
        nxt_resp.rdata = pins_in.muxed_addr_data_lines_in;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_ff <= '{ack: 1'h0, rdata: ext_bus_pkg::RDATA_RESET, released: 1'h0};
    end else begin
      resp_ff <= nxt_resp;
    end
  end

  // Pin levels follow the state that is being entered
  always_comb begin
    nxt_pins.muxed_addr_data_lines_out = nxt_req.addr[ext_bus_pkg::DATA_W-1:0];
    nxt_pins.muxed_addr_data_lines_oe = 1'h0;
    nxt_pins.address_lines = nxt_req.addr;
    nxt_pins.address_lines_oe = 1'h1;
    nxt_pins.read_strobe_n = ext_bus_pkg::STROBE_IDLE;
    nxt_pins.low_byte_store_strobe_n = ext_bus_pkg::STROBE_IDLE;
    nxt_pins.high_byte_store_strobe_n = ext_bus_pkg::STROBE_IDLE;
    nxt_pins.read_write_dir = ext_bus_pkg::DIR_READ;
    nxt_pins.row_strobe_n = ext_bus_pkg::STROBE_IDLE;
    nxt_pins.select_line_n = {ext_bus_pkg::AREA_N{ext_bus_pkg::STROBE_IDLE}};
    nxt_pins.control_oe = 1'h1;
    nxt_pins.bus_release_grant_n = 1'h1;
    case (nxt_state)
      ext_bus_pkg::ST_ADDR, ext_bus_pkg::ST_STROBE: begin
        nxt_pins.muxed_addr_data_lines_oe = 1'h1;
        nxt_pins.read_write_dir = nxt_req.write ? ext_bus_pkg::DIR_WRITE
                                                : ext_bus_pkg::DIR_READ;
        nxt_pins.row_strobe_n = ~nxt_dram;
        nxt_pins.select_line_n = ~nxt_hit;
        if (nxt_dram) begin
          // Area zero pin acts as column strobe, only in the strobe phase
          nxt_pins.select_line_n[0] = (nxt_state != ext_bus_pkg::ST_STROBE);
        end
        if (nxt_state == ext_bus_pkg::ST_STROBE) begin
          if (nxt_req.write) begin
            nxt_pins.muxed_addr_data_lines_out = nxt_req.wdata;
            nxt_pins.low_byte_store_strobe_n = ~nxt_req.byte_en[0];
            nxt_pins.high_byte_store_strobe_n = ~nxt_req.byte_en[1];
          end else begin
            nxt_pins.muxed_addr_data_lines_oe = 1'h0;
            nxt_pins.read_strobe_n = 1'h0;
          end
        end
      end
      ext_bus_pkg::ST_FLOAT, ext_bus_pkg::ST_HOLD: begin
        nxt_pins.address_lines_oe = 1'h0;
        nxt_pins.control_oe = 1'h0;
        nxt_pins.bus_release_grant_n = (nxt_state != ext_bus_pkg::ST_HOLD);
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pins_ff <= '{
        muxed_addr_data_lines_out: ext_bus_pkg::RDATA_RESET,
        muxed_addr_data_lines_oe: 1'h0,
        address_lines: ext_bus_pkg::ADDR_RESET,
        address_lines_oe: 1'h1,
        read_strobe_n: ext_bus_pkg::STROBE_IDLE,
        low_byte_store_strobe_n: ext_bus_pkg::STROBE_IDLE,
        high_byte_store_strobe_n: ext_bus_pkg::STROBE_IDLE,
        read_write_dir: ext_bus_pkg::DIR_READ,
        row_strobe_n: ext_bus_pkg::STROBE_IDLE,
        select_line_n: {ext_bus_pkg::AREA_N{ext_bus_pkg::STROBE_IDLE}},
        control_oe: 1'h1,
        bus_release_grant_n: 1'h1
      };
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  assign pins_out = pins_ff;
  assign cpu_resp = resp_ff;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_read_strobe;
    state_ff == ext_bus_pkg::ST_STROBE && !req_ff.write;
  endsequence

  sequence s_floated;
    !pins_ff.control_oe && !pins_ff.address_lines_oe && !pins_ff.muxed_addr_data_lines_oe;
  endsequence

  // Address phase then strobe phase of one external cycle
  sequence s_addr_phase;
    state_ff == ext_bus_pkg::ST_ADDR && pins_ff.control_oe && pins_ff.address_lines_oe;
  endsequence

  sequence s_strobe_phase;
    state_ff == ext_bus_pkg::ST_STROBE && pins_ff.address_lines == req_ff.addr;
  endsequence

  chk_read_strobe: assert property (s_read_strobe |-> !pins_ff.read_strobe_n)
    else $error("read strobe idle during read strobe phase");

  chk_low_store: assert property (state_ff == ext_bus_pkg::ST_STROBE && req_ff.write
      |-> pins_ff.low_byte_store_strobe_n == !req_ff.byte_en[0])
    else $error("low byte store strobe wrong");

  chk_high_store: assert property (state_ff == ext_bus_pkg::ST_STROBE && req_ff.write
      |-> pins_ff.high_byte_store_strobe_n == !req_ff.byte_en[1])
    else $error("high byte store strobe wrong");

  chk_wait_stretch: assert property (state_ff == ext_bus_pkg::ST_STROBE
      && !pins_in.bus_wait_n |=> state_ff == ext_bus_pkg::ST_STROBE
      && !cpu_resp.ack)
    else $error("cycle ended while wait held");

  chk_float_pins: assert property (!pins_in.bus_release_request_n
      && state_ff == ext_bus_pkg::ST_IDLE |=> s_floated ##1 s_floated)
    else $error("pins not floated after release request");

  chk_grant_after: assert property (!pins_ff.bus_release_grant_n |->
      !pins_ff.control_oe && !pins_ff.address_lines_oe
      && !pins_ff.muxed_addr_data_lines_oe && $past(!pins_ff.control_oe))
    else $error("grant given before pins floated");

  chk_dir_level: assert property (state_ff inside {ext_bus_pkg::ST_ADDR,
      ext_bus_pkg::ST_STROBE} |-> pins_ff.read_write_dir == !req_ff.write)
    else $error("direction output wrong");

  chk_row_strobe: assert property (state_ff == ext_bus_pkg::ST_STROBE
      |-> pins_ff.row_strobe_n == !dram_cyc)
    else $error("row strobe wrong for DRAM access");

  chk_sel_zero: assert property (state_ff == ext_bus_pkg::ST_ADDR && !dram_cyc
      |-> pins_ff.select_line_n[0] == !hit_ff[0] ##1
      pins_ff.select_line_n[0] == !hit_ff[0])
    else $error("select line zero wrong");

  chk_cas_zero: assert property (state_ff == ext_bus_pkg::ST_ADDR && dram_cyc
      |-> pins_ff.select_line_n[0] ##1
      (!pins_ff.select_line_n[0] && state_ff == ext_bus_pkg::ST_STROBE))
    else $error("column strobe zero wrong");

  chk_grant_between: assert property ($fell(pins_ff.bus_release_grant_n)
      |-> $past(state_ff, 2) == ext_bus_pkg::ST_IDLE)
    else $error("grant given inside a bus cycle");

  chk_grant_drop: assert property (!pins_ff.bus_release_grant_n
      && pins_in.bus_release_request_n |=> pins_ff.bus_release_grant_n
      && pins_ff.control_oe && pins_ff.address_lines_oe)
    else $error("grant not withdrawn after request dropped");

  chk_cycle_steps: assert property (state_ff == ext_bus_pkg::ST_IDLE && cpu_req.valid
      && pins_in.bus_release_request_n |=> s_addr_phase ##1 s_strobe_phase)
    else $error("bus cycle phases out of order");

  chk_idle_selects: assert property (state_ff == ext_bus_pkg::ST_IDLE
      |-> pins_ff.select_line_n == {ext_bus_pkg::AREA_N{ext_bus_pkg::STROBE_IDLE}}
      && pins_ff.read_strobe_n && pins_ff.low_byte_store_strobe_n
      && pins_ff.high_byte_store_strobe_n)
    else $error("strobe or select active while idle");

  chk_read_data: assert property (state_ff == ext_bus_pkg::ST_END && !req_ff.write
      |-> cpu_resp.rdata == $past(pins_in.muxed_addr_data_lines_in))
    else $error("read data not taken at strobe end");

  chk_write_data: assert property (state_ff == ext_bus_pkg::ST_STROBE && req_ff.write
      |-> pins_ff.muxed_addr_data_lines_oe && pins_ff.muxed_addr_data_lines_out == req_ff.wdata)
    else $error("write data not on data lines");

  chk_read_turn: assert property (s_read_strobe
      |-> !pins_ff.muxed_addr_data_lines_oe && pins_ff.read_write_dir == ext_bus_pkg::DIR_READ)
    else $error("data lines driven during read strobe");

  chk_grant_hold: assert property (state_ff == ext_bus_pkg::ST_HOLD
      && !pins_in.bus_release_request_n |=> !pins_ff.bus_release_grant_n && !pins_ff.control_oe)
    else $error("grant lost while request held");

  chk_row_addr: assert property (state_ff == ext_bus_pkg::ST_ADDR
      |-> pins_ff.row_strobe_n == !dram_cyc)
    else $error("row strobe wrong in address phase");

  chk_dir_idle: assert property (state_ff == ext_bus_pkg::ST_IDLE
      |-> pins_ff.read_write_dir == ext_bus_pkg::DIR_READ)
    else $error("direction not read level while idle");

  chk_released_quiet: assert property (cpu_resp.released
      |-> !cpu_resp.ack && !pins_ff.control_oe && !pins_ff.address_lines_oe)
    else $error("bus driven while released");

endmodule : external_bus_pin_interface

/* pkg/ext_bus_pkg.sv */
package ext_bus_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int AREA_N = 3;

  // Idle level of every active-low strobe and select
  localparam logic STROBE_IDLE = 1'h1;
  // Direction level: high for read and dummy cycles, low for write
  localparam logic DIR_READ = 1'h1;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  // Shortest strobe phase in clock cycles; wait requests lengthen it
  localparam int STROBE_MIN_CYC = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_STROBE = 3'h2,
    ST_END = 3'h3,
    ST_FLOAT = 3'h4,
    ST_HOLD = 3'h5
  } bus_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] byte_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic released;
  } cpu_resp_t;

  typedef struct packed {
    logic [AREA_N-1:0][ADDR_W-1:0] base;
    logic [AREA_N-1:0][ADDR_W-1:0] mask;
    logic area0_dram;
  } area_cfg_t;

  typedef struct packed {
    logic [DATA_W-1:0] muxed_addr_data_lines_in;
    logic bus_wait_n;
    logic bus_release_request_n;
  } pins_in_t;

  typedef struct packed {
    logic [DATA_W-1:0] muxed_addr_data_lines_out;
    logic muxed_addr_data_lines_oe;
    logic [ADDR_W-1:0] address_lines;
    logic address_lines_oe;
    logic read_strobe_n;
    logic low_byte_store_strobe_n;
    logic high_byte_store_strobe_n;
    logic read_write_dir;
    logic row_strobe_n;
    logic [AREA_N-1:0] select_line_n;
    logic control_oe;
    logic bus_release_grant_n;
  } pins_out_t;

endpackage : ext_bus_pkg

/* tb/ext_bus_partner.sv */
`timescale 1ns/100ps
module ext_bus_partner (
  // Clock
  input wire logic sys_clk,
  // Commands from the bench
  input wire logic dma_req,
  input wire logic [3:0] waits,
  // Device pins
  input wire ext_bus_pkg::pins_out_t pin_o,
  output ext_bus_pkg::pins_in_t pin_i
);
  logic [3:0] wcnt = 4'h0;
  logic [15:0] last = 16'h0000;
  logic rd;
  logic act;

  assign rd = pin_o.control_oe && !pin_o.read_strobe_n;
  assign act = pin_o.control_oe && !(&{pin_o.read_strobe_n, pin_o.low_byte_store_strobe_n,
    pin_o.high_byte_store_strobe_n});

  always @(posedge sys_clk) begin
    wcnt <= act ? wcnt + 4'h1 : 4'h0;
    last <= pin_i.muxed_addr_data_lines_in;
  end

  // Read data follows the address; an undriven bus shows the inverse of its last level.
  // Slow part holds wait low for the first strobe cycles.
  // The external controller only asks for the bus and never targets internal space.
  assign pin_i = '{
    muxed_addr_data_lines_in: pin_o.muxed_addr_data_lines_oe ? pin_o.muxed_addr_data_lines_out
      : rd ? pin_o.address_lines[15:0] ^ 16'h5A5A : ~last,
    bus_wait_n: !(act && wcnt < waits),
    bus_release_request_n: !dma_req
  };
endmodule : ext_bus_partner

/* tb/tb_external_bus_pin_interface.sv */
`timescale 1ns/100ps
module tb_external_bus_pin_interface;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  ext_bus_pkg::cpu_req_t cpu_req = '0;
  ext_bus_pkg::cpu_resp_t cpu_resp;
  ext_bus_pkg::area_cfg_t area_cfg;
  ext_bus_pkg::pins_in_t pins_in;
  ext_bus_pkg::pins_out_t pins_out;
  logic dma_req = 1'h0;
  logic [3:0] waits = 4'h0;
  int miscompares = 0;
  int compares = 0;
  int cyc;
  logic seen_rd, seen_lo, seen_hi, seen_row, dir_bad;
  logic [2:0] sel_low;
  logic [15:0] ad_strobe;
  logic [23:0] addr_seen;

  always #50 sys_clk = ~sys_clk;

  external_bus_pin_interface external_bus_pin_interface_i (.sys_clk(sys_clk), .rst(rst),
    .cpu_req(cpu_req), .cpu_resp(cpu_resp), .area_cfg(area_cfg), .pins_in(pins_in),
    .pins_out(pins_out));
  ext_bus_partner ext_bus_partner_i (.sys_clk(sys_clk), .dma_req(dma_req), .waits(waits),
    .pin_o(pins_out), .pin_i(pins_in));

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // One internal cycle, recording what the pins did until the answer
  task automatic bus_op(input logic w, input logic [1:0] be, input logic [23:0] a,
      input logic [15:0] d);
    logic act;
    {seen_rd, seen_lo, seen_hi, seen_row, dir_bad, sel_low} = '0;
    cyc = 0;
    @(posedge sys_clk);
    cpu_req <= '{1'h1, w, be, a, d};
    while (cpu_resp.ack !== 1'h1 && cyc < 30) begin
      @(posedge sys_clk);
      #1;
      cyc++;
      act = !(&{pins_out.read_strobe_n, pins_out.low_byte_store_strobe_n,
        pins_out.high_byte_store_strobe_n});
      seen_rd |= pins_out.read_strobe_n === 1'h0;
      seen_lo |= pins_out.low_byte_store_strobe_n === 1'h0;
      seen_hi |= pins_out.high_byte_store_strobe_n === 1'h0;
      seen_row |= pins_out.row_strobe_n === 1'h0;
      sel_low |= ~pins_out.select_line_n;
      dir_bad |= act && pins_out.read_write_dir !== (w ? ext_bus_pkg::DIR_WRITE :
        ext_bus_pkg::DIR_READ);
      if (act && w) ad_strobe = pins_out.muxed_addr_data_lines_out;
      if (act) addr_seen = pins_out.address_lines;
    end
    @(posedge sys_clk);
    cpu_req.valid <= 1'h0;
  endtask : bus_op

  task automatic t_read;
    area_cfg.area0_dram <= 1'h1;
    waits <= 4'h2;
    bus_op(1'h0, 2'h3, 24'h100010, 16'h0000);
    check(seen_rd === 1'h1 && dir_bad === 1'h0, "read strobe or direction");
    check(seen_row === 1'h1 && sel_low[0] === 1'h1, "dram strobes");
    check(cyc == 5, "stretched cycle length");
    check(addr_seen === 24'h100010, "address lines during read strobe");
    check(cpu_resp.rdata === (16'h0010 ^ 16'h5A5A), "read data");
  endtask : t_read

  task automatic t_write;
    logic [15:0] d;
    area_cfg.area0_dram <= 1'h0;
    waits <= 4'h0;
    for (int be = 1; be < 4; be++) begin
      d = 16'h1234 + 16'(be);
      bus_op(1'h1, 2'(be), 24'h100020, d);
      check(seen_lo === be[0] && seen_hi === be[1] && seen_rd === 1'h0, "store strobes");
      check(dir_bad === 1'h0 && ad_strobe === d, "write direction or data");
      check(sel_low === 3'h1 && seen_row === 1'h0, "select zero in range");
      check(addr_seen === 24'h100020, "address lines during write strobe");
    end
    for (int i = 0; i < 3; i++) begin
      bus_op(1'h1, 2'h3, 24'h200000 + 24'(i) * 24'h100000, 16'hBEEF);
      check(sel_low === (i < 2 ? 3'(2 << i) : 3'h0), "select outside range");
    end
  endtask : t_write

  task automatic t_release;
    int n;
    cyc = 0;
    n = 0;
    @(posedge sys_clk);
    cpu_req <= '{1'h1, 1'h0, 2'h3, 24'h000100, 16'h0000};
    @(posedge sys_clk);
    dma_req <= 1'h1;
    while (pins_out.bus_release_grant_n !== 1'h0 && n < 30) begin
      @(posedge sys_clk);
      if (cyc > 0) cpu_req.valid <= 1'h0;
      #1;
      n++;
      if (cpu_resp.ack === 1'h1) cyc = n;
    end
    check(cyc > 0 && n > cyc && n < 30, "grant only after cycle end");
    check({pins_out.muxed_addr_data_lines_oe, pins_out.address_lines_oe, pins_out.control_oe,
      cpu_resp.released} === 4'h1, "pins float under grant");
    @(posedge sys_clk);
    cpu_req <= '{1'h1, 1'h1, 2'h3, 24'h100000, 16'h55AA};
    n = 0;
    repeat (5) begin
      @(posedge sys_clk);
      #1;
      if (cpu_resp.ack !== 1'h0 || pins_out.control_oe !== 1'h0) n++;
    end
    check(n == 0, "cycle ran while bus released");
    @(posedge sys_clk);
    dma_req <= 1'h0;
    @(posedge sys_clk);
    #1;
    check({pins_out.bus_release_grant_n, pins_out.address_lines_oe, pins_out.control_oe,
      cpu_resp.released} === 4'hE, "grant withdrawn");
    n = 0;
    while (cpu_resp.ack !== 1'h1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    cpu_req.valid <= 1'h0;
    check(n < 20, "held request served after release");
  endtask : t_release

  initial begin
    area_cfg <= '{{24'h300000, 24'h200000, 24'h100000}, {3{24'hF00000}}, 1'h0};
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    t_read();
    t_write();
    t_release();
    end_of_test();
  end

  initial begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    $display("wrong value at %0t: run did not finish", $time);
    end_of_test();
  end
endmodule : tb_external_bus_pin_interface
